/* File: src/mem_map_pkg.sv */
// Function
// - Low 640 KB always goes to memory
// - Thirteen segments carry read and write enables
// - Frame buffer steered by VGA steering bits
// - Internal targets first, internal graphics wins
// - Bridge or hub chosen by enable, mono
// - SMM processor frame buffer goes to memory
// - Non-SMM processor sees plain video buffer
// - Bridge and hub cycles never reach SMRAM
// - Mono range decoded and steered separately
// - Mono I/O ports follow mono steering
// - Eight expansion segments, direction gated
// - Disabled direction passes downstream, no relocation
// - Four extended BIOS segments, per direction
// - System BIOS disabled both ways at reset
// - Shadowing purely by per-direction attributes
// - 1 MB to top goes to memory
// - Hole 15-16 MB goes downstream when enabled
// - Memory behind hole is not remapped
// - Top of memory to 4 GB is bus space
// - No APIC relocation, top of memory capped at 2 GB
// - Above 4 GB terminated locally, reads zero
package mem_map_pkg;

   typedef enum logic [4:0] {
      TGT_SDRAM = 5'h01,
      TGT_HUB   = 5'h02,
      TGT_BRG   = 5'h04,
      TGT_IGT   = 5'h08,
      TGT_LOCAL = 5'h10
   } target_t;

   typedef enum logic [1:0] {
      ORG_CPU = 2'h0,
      ORG_BRG = 2'h1,
      ORG_HUB = 2'h2
   } origin_t;

   typedef struct packed {
      logic [35:0] addr;
      logic        is_io;
      logic        is_write;
      logic        smm;
      origin_t     origin;
   } cycle_t;

   typedef struct packed {
      target_t target;
      logic    zero_read;
      logic    discard;
   } route_t;

   // Register map over the plain port
   localparam logic [3:0] REG_SEG_RD_EN = 4'h0;
   localparam logic [3:0] REG_SEG_WE   = 4'h1;
   localparam logic [3:0] REG_LEGACY   = 4'h2;
   localparam logic [3:0] REG_TOP_MEM  = 4'h3;
   localparam logic [3:0] REG_STATUS   = 4'h4;

   localparam int NUM_SEG = 13;
   localparam logic [12:0] SEG_RST = 13'h0000;

   // Legacy control bit positions
   localparam int LB_IGT_EN = 0;
   localparam int LB_VGA_EN = 1;
   localparam int LB_MONO_PRES = 2;
   localparam int LB_SMRAM  = 3;
   localparam int LB_HOLE   = 4;
   localparam logic [4:0] LEGACY_RST = 5'h00;

   // Top of memory in 1 MB units, at most 2 GB
   localparam logic [11:0] TOP_MEM_MAX = 12'h800;
   localparam logic [11:0] TOP_MEM_RST = 12'h010;

   localparam logic [35:0] A_DOS_END  = 36'h0000a0000;
   localparam logic [35:0] A_VGA_END  = 36'h0000c0000;
   localparam logic [35:0] A_MONO_LO  = 36'h0000b0000;
   localparam logic [35:0] A_MONO_END = 36'h0000b8000;
   localparam logic [35:0] A_1MB      = 36'h000100000;
   localparam logic [35:0] A_HOLE_LO  = 36'h000f00000;
   localparam logic [35:0] A_HOLE_END = 36'h001000000;
   localparam logic [35:0] A_4GB      = 36'h100000000;
   localparam logic [35:0] A_SEG_BASE = 36'h0000c0000;
   localparam logic [35:0] A_SYSBIOS  = 36'h0000f0000;
   localparam int SEG_SHIFT = 14;

endpackage

/* File: src/legacy_memory_map_decoder.sv */
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module legacy_memory_map_decoder
   import mem_map_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Cycle in, route out
   input  wire cycle_t      cyc,
   input  wire logic        cyc_valid,
   output route_t           route_r,
   output logic             route_valid_r
);

   ////////////////////////////////////////////////////////////////////////
   logic [12:0] seg_rd_en_r;
   logic [12:0] seg_we_r;
   logic [4:0]  legacy_r;
   logic [11:0] top_mem_r;
   logic [31:0] rdata_r;
   route_t      route_nxt;
   logic [31:0] hub_count_r;

   // Attributes take effect the cycle after the write
   always_ff @(posedge clk) begin
      if (!resetn) begin
         seg_rd_en_r <= SEG_RST;
         seg_we_r    <= SEG_RST;
         legacy_r    <= LEGACY_RST;
         top_mem_r   <= TOP_MEM_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            REG_SEG_RD_EN: seg_rd_en_r <= reg_wdata[12:0];
            REG_SEG_WE: seg_we_r <= reg_wdata[12:0];
            REG_LEGACY: legacy_r <= reg_wdata[4:0];
            // Clamp keeps the decode within 2 GB
            REG_TOP_MEM: top_mem_r <= (reg_wdata[11:0] > TOP_MEM_MAX) ? TOP_MEM_MAX
                                                                   : reg_wdata[11:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         hub_count_r <= 32'h0000_0000;
      end else if (cyc_valid && route_nxt.target == TGT_HUB) begin
         hub_count_r <= hub_count_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_SEG_RD_EN: rdata_r <= {19'h0, seg_rd_en_r};
            REG_SEG_WE: rdata_r <= {19'h0, seg_we_r};
            REG_LEGACY: rdata_r <= {27'h0, legacy_r};
            REG_TOP_MEM: rdata_r <= {20'h0, top_mem_r};
            REG_STATUS: rdata_r <= hub_count_r;
            default:    rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end
   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // Video target choice shared by the VGA and mono paths
   function automatic target_t vga_target(input logic mono, input logic [4:0] lg);
      target_t t;
      t = TGT_HUB;
      if (lg[LB_IGT_EN] && !(mono && lg[LB_MONO_PRES])) begin
         t = TGT_IGT;
      end else if (lg[LB_VGA_EN] && !(mono && lg[LB_MONO_PRES])) begin
         t = TGT_BRG;
      end
      return t;
   endfunction

   logic [35:0] a;
   logic [3:0]  seg_idx;
   logic        in_seg;
   logic        seg_ok;
   logic        mono_io;
   logic        mono_mem;
   logic [35:0] top_mem_addr;
   logic        video_plain;

   always_comb begin
      a        = cyc.addr;
      top_mem_addr = {4'h0, top_mem_r, 20'h00000};
      in_seg   = (a >= A_SEG_BASE) && (a < A_1MB);
      seg_idx  = 4'h0;
      if (in_seg) begin
         seg_idx = (a >= A_SYSBIOS) ? 4'hc : 4'((a - A_SEG_BASE) >> SEG_SHIFT);
      end
      seg_ok   = cyc.is_write ? seg_we_r[seg_idx] : seg_rd_en_r[seg_idx];
      mono_mem = (a >= A_MONO_LO) && (a < A_MONO_END);
      // Video range cycle that is not an SMM processor access to SMRAM
      video_plain = (a >= A_DOS_END) && (a < A_VGA_END) &&
                    !(legacy_r[LB_SMRAM] && cyc.smm && cyc.origin == ORG_CPU);
      mono_io  = (a[15:0] == 16'h03b4) || (a[15:0] == 16'h03b5) ||
                 (a[15:0] == 16'h03b8) || (a[15:0] == 16'h03b9) ||
                 (a[15:0] == 16'h03ba) || (a[15:0] == 16'h03bf);
      route_nxt = '{target: TGT_HUB, zero_read: 1'b0, discard: 1'b0};
      if (cyc.is_io) begin
         if (mono_io) begin
            route_nxt.target = vga_target(1'b1, legacy_r);
         end
      end else if (a >= A_4GB) begin
         route_nxt.target    = TGT_LOCAL;
         route_nxt.zero_read = !cyc.is_write;
         route_nxt.discard   = cyc.is_write;
      end else if (a < A_DOS_END) begin
         route_nxt.target = TGT_SDRAM;
      end else if (a < A_VGA_END) begin
         if (legacy_r[LB_SMRAM] && cyc.smm && cyc.origin == ORG_CPU) begin
            route_nxt.target = TGT_SDRAM;
         end else begin
            route_nxt.target = vga_target(mono_mem, legacy_r);
         end
      end else if (in_seg) begin
         if (seg_ok) begin
            route_nxt.target = TGT_SDRAM;
         end else begin
            route_nxt.target = TGT_HUB;
         end
      end else if (legacy_r[LB_HOLE] && a >= A_HOLE_LO && a < A_HOLE_END) begin
         route_nxt.target = TGT_HUB;
      end else if (a < top_mem_addr) begin
         route_nxt.target = TGT_SDRAM;
      end else begin
         route_nxt.target = TGT_HUB;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         route_r       <= '{target: TGT_HUB, zero_read: 1'b0, discard: 1'b0};
         route_valid_r <= 1'b0;
      end else begin
         route_r       <= route_nxt;
         route_valid_r <= cyc_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_above4g;
      cyc_valid && !cyc.is_io && cyc.addr >= A_4GB;
   endsequence

   property p_dos;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && cyc.addr < A_DOS_END) |=> route_r.target == TGT_SDRAM;
   endproperty
   a_dos: assert property (p_dos) else $error("DOS area not routed to memory");

   property p_above4g;
      @(posedge clk) disable iff (!resetn)
      s_above4g |=> route_r.target == TGT_LOCAL && (route_r.zero_read != route_r.discard);
   endproperty
   a_above4g: assert property (p_above4g) else $error("High cycle not terminated");

   property p_bios_reset;
      @(posedge clk)
      !resetn |=> seg_rd_en_r[12] == 1'b0 && seg_we_r[12] == 1'b0;
   endproperty
   a_bios_reset: assert property (p_bios_reset) else $error("BIOS attrs not cleared");

   property p_smm_only_cpu;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && cyc.origin != ORG_CPU && cyc.addr >= A_DOS_END &&
       cyc.addr < A_VGA_END) |=> route_r.target != TGT_SDRAM;
   endproperty
   a_smm_only_cpu: assert property (p_smm_only_cpu) else $error("SMRAM reached");

   property p_smm_cpu;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && cyc.smm && cyc.origin == ORG_CPU && legacy_r[LB_SMRAM] &&
       cyc.addr >= A_DOS_END && cyc.addr < A_VGA_END) |=> route_r.target == TGT_SDRAM;
   endproperty
   a_smm_cpu: assert property (p_smm_cpu) else $error("SMM cycle not to memory");

   property p_hole;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && legacy_r[LB_HOLE] && cyc.addr >= A_HOLE_LO &&
       cyc.addr < A_HOLE_END) |=> route_r.target == TGT_HUB;
   endproperty
   a_hole: assert property (p_hole) else $error("Hole not forwarded");

   property p_seg_gate;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && in_seg && !seg_ok) |=> route_r.target == TGT_HUB;
   endproperty
   a_seg_gate: assert property (p_seg_gate) else $error("Disabled segment used");

   property p_top_cap;
      @(posedge clk) disable iff (!resetn)
      reg_wr && reg_addr == REG_TOP_MEM |=> top_mem_r <= TOP_MEM_MAX;
   endproperty
   a_top_cap: assert property (p_top_cap) else $error("Top of memory above 2 GB");

   property p_valid;
      @(posedge clk) disable iff (!resetn)
      cyc_valid |=> route_valid_r ##1 (route_valid_r == $past(cyc_valid));
   endproperty
   a_valid: assert property (p_valid) else $error("Route valid lost");

   ////////////////////////////////////////////////////////////////////////
   // Video steering checks; SMM processor cycles to SMRAM are excluded
   sequence s_video_hit;
      cyc_valid && !cyc.is_io && video_plain;
   endsequence

   property p_igt_first;
      @(posedge clk) disable iff (!resetn)
      s_video_hit ##0 (legacy_r[LB_IGT_EN] && !mono_mem)
      |=> route_r.target == TGT_IGT;
   endproperty
   a_igt_first: assert property (p_igt_first) else $error("Internal graphics lost");

   property p_vga_brg;
      @(posedge clk) disable iff (!resetn)
      s_video_hit ##0 (!legacy_r[LB_IGT_EN] && legacy_r[LB_VGA_EN] && !mono_mem)
      |=> route_r.target == TGT_BRG;
   endproperty
   a_vga_brg: assert property (p_vga_brg) else $error("VGA not to bridge");

   property p_vga_hub;
      @(posedge clk) disable iff (!resetn)
      s_video_hit ##0 (!legacy_r[LB_IGT_EN] && !legacy_r[LB_VGA_EN])
      |=> route_r.target == TGT_HUB;
   endproperty
   a_vga_hub: assert property (p_vga_hub) else $error("VGA not to hub");

   property p_non_smm;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && !cyc.smm && cyc.addr >= A_DOS_END &&
       cyc.addr < A_VGA_END)
      |=> route_r.target != TGT_SDRAM;
   endproperty
   a_non_smm: assert property (p_non_smm) else $error("Non-SMM cycle hit SMRAM");

   property p_mono_mem;
      @(posedge clk) disable iff (!resetn)
      s_video_hit ##0 (mono_mem && legacy_r[LB_MONO_PRES])
      |=> route_r.target == TGT_HUB;
   endproperty
   a_mono_mem: assert property (p_mono_mem) else $error("Mono range not to hub");

   // I/O space: only the mono ports are steered
   property p_mono_io;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && cyc.is_io && mono_io && legacy_r[LB_MONO_PRES])
      |=> route_r.target == TGT_HUB;
   endproperty
   a_mono_io: assert property (p_mono_io) else $error("Mono port not to hub");

   property p_io_other;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && cyc.is_io && !mono_io)
      |=> route_r.target == TGT_HUB;
   endproperty
   a_io_other: assert property (p_io_other) else $error("Other port not to hub");

   ////////////////////////////////////////////////////////////////////////
   // Segment attribute checks
   property p_seg_open;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && in_seg && seg_ok)
      |=> route_r.target == TGT_SDRAM;
   endproperty
   a_seg_open: assert property (p_seg_open) else $error("Enabled segment missed");

   property p_seg_wr_gate;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && in_seg && cyc.is_write && !seg_we_r[seg_idx])
      |=> route_r.target == TGT_HUB;
   endproperty
   a_seg_wr_gate: assert property (p_seg_wr_gate) else $error("Write gate ignored");

   property p_seg_rd_gate;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && in_seg && !cyc.is_write && !seg_rd_en_r[seg_idx])
      |=> route_r.target == TGT_HUB;
   endproperty
   a_seg_rd_gate: assert property (p_seg_rd_gate) else $error("Read gate ignored");

   ////////////////////////////////////////////////////////////////////////
   // Extended area checks
   property p_ext_mem;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && cyc.addr >= A_1MB && cyc.addr < top_mem_addr &&
       !(legacy_r[LB_HOLE] && cyc.addr >= A_HOLE_LO && cyc.addr < A_HOLE_END))
      |=> route_r.target == TGT_SDRAM;
   endproperty
   a_ext_mem: assert property (p_ext_mem) else $error("Main memory missed");

   property p_above_top;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && !cyc.is_io && cyc.addr >= A_1MB && cyc.addr >= top_mem_addr &&
       cyc.addr < A_4GB)
      |=> route_r.target == TGT_HUB;
   endproperty
   a_above_top: assert property (p_above_top) else $error("Bus space not to hub");

   property p_flags_local;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && (cyc.is_io || cyc.addr < A_4GB))
      |=> !route_r.zero_read && !route_r.discard;
   endproperty
   a_flags_local: assert property (p_flags_local) else $error("Stray termination flag");

   property p_onehot;
      @(posedge clk) disable iff (!resetn)
      cyc_valid |=> $onehot(route_r.target);
   endproperty
   a_onehot: assert property (p_onehot) else $error("Target not one-hot");

   ////////////////////////////////////////////////////////////////////////
   // Register side checks
   property p_legacy_next;
      @(posedge clk) disable iff (!resetn)
      (reg_wr && reg_addr == REG_LEGACY) |=> legacy_r == $past(reg_wdata[4:0]);
   endproperty
   a_legacy_next: assert property (p_legacy_next) else $error("Legacy bits late");

   property p_top_rd;
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == REG_TOP_MEM) |=> reg_rdata == {20'h0, $past(top_mem_r)};
   endproperty
   a_top_rd: assert property (p_top_rd) else $error("Top of memory read wrong");

   property p_valid_drop;
      @(posedge clk) disable iff (!resetn)
      !cyc_valid |=> !route_valid_r;
   endproperty
   a_valid_drop: assert property (p_valid_drop) else $error("Route valid stuck");

   // Count must step exactly once per hub-bound cycle
   property p_hub_count;
      @(posedge clk) disable iff (!resetn)
      (cyc_valid && route_nxt.target == TGT_HUB)
      |=> hub_count_r == $past(hub_count_r) + 32'h0000_0001;
   endproperty
   a_hub_count: assert property (p_hub_count) else $error("Hub count missed");

endmodule

/* File: dv/host_bus_model.sv */
`timescale 1ns/100ps
module host_bus_model
   import mem_map_pkg::*;
(
   // Clock
   input  wire logic clk,
   // Cycle toward the decoder
   output cycle_t    cyc,
   output logic      cyc_valid
);
   initial begin
      cyc       = '0;
      cyc_valid = 1'b0;
   end

   // One cycle per call; idle address inverted so no stale match
   task automatic issue(input cycle_t c);
      @(posedge clk);
      cyc       <= c;
      cyc_valid <= 1'b1;
      @(posedge clk);
      cyc.addr  <= ~c.addr;
      cyc_valid <= 1'b0;
   endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top
   import mem_map_pkg::*;
;
   logic        clk;
   logic        resetn;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   cycle_t      cyc;
   logic        cyc_valid;
   route_t      route_r;
   logic        route_valid_r;
   int          n_errors;
   int          n_checks;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   host_bus_model i_host_bus_model (.clk(clk), .cyc(cyc), .cyc_valid(cyc_valid));

   legacy_memory_map_decoder i_legacy_memory_map_decoder (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cyc(cyc),
      .cyc_valid(cyc_valid), .route_r(route_r), .route_valid_r(route_valid_r));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (n_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // Flags are {io, write, smm}; route checked with its valid bit
   task automatic g(input logic [35:0] a, input logic [2:0] f, input origin_t o,
                    input target_t t, input logic [1:0] fl = 2'b00);
      i_host_bus_model.issue(cycle_t'{a, f[2], f[1], f[0], o});
      #1;
      chk({24'h0, route_valid_r, route_r}, {24'h0, 1'b1, t, fl});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      n_errors  = 0;
      n_checks  = 0;
      resetn    = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk({24'h0, route_valid_r, route_r}, {24'h0, 1'b0, TGT_HUB, 2'b00});
      rd(REG_SEG_RD_EN, 32'h0);
      rd(REG_SEG_WE, 32'h0);
      rd(REG_TOP_MEM, 32'h10);
      rd(4'hf, 32'h0);
      g(36'h000050000, 3'b000, ORG_CPU, TGT_SDRAM);
      g(36'h00009fff0, 3'b010, ORG_HUB, TGT_SDRAM);
      g(36'h0000a0000, 3'b000, ORG_CPU, TGT_HUB);
      wr(REG_LEGACY, 32'h2);
      g(36'h0000a0000, 3'b000, ORG_CPU, TGT_BRG);
      g(36'h0000b7ff0, 3'b010, ORG_CPU, TGT_BRG);
      g(36'h0000003ba, 3'b100, ORG_CPU, TGT_BRG);
      g(36'h0000003c0, 3'b100, ORG_CPU, TGT_HUB);
      wr(REG_LEGACY, 32'h3);
      g(36'h0000bfff0, 3'b000, ORG_CPU, TGT_IGT);
      wr(REG_LEGACY, 32'h6);
      g(36'h0000b0000, 3'b000, ORG_CPU, TGT_HUB);
      g(36'h0000a0000, 3'b000, ORG_CPU, TGT_BRG);
      g(36'h0000003b4, 3'b100, ORG_CPU, TGT_HUB);
      g(36'h0000003bf, 3'b110, ORG_CPU, TGT_HUB);
      wr(REG_LEGACY, 32'ha);
      g(36'h0000a0000, 3'b001, ORG_CPU, TGT_SDRAM);
      g(36'h0000a0000, 3'b000, ORG_CPU, TGT_BRG);
      g(36'h0000a0000, 3'b001, ORG_HUB, TGT_BRG);
      g(36'h0000bfff0, 3'b011, ORG_BRG, TGT_BRG);
      g(36'h0000c0000, 3'b000, ORG_CPU, TGT_HUB);
      wr(REG_SEG_RD_EN, 32'h1);
      g(36'h0000c0000, 3'b000, ORG_CPU, TGT_SDRAM);
      g(36'h0000c3ff0, 3'b010, ORG_CPU, TGT_HUB);
      g(36'h0000c4000, 3'b000, ORG_CPU, TGT_HUB);
      wr(REG_SEG_WE, 32'h100);
      g(36'h0000e0000, 3'b010, ORG_CPU, TGT_SDRAM);
      g(36'h0000e0000, 3'b000, ORG_CPU, TGT_HUB);
      g(36'h0000f0000, 3'b000, ORG_CPU, TGT_HUB);
      g(36'h0000f0000, 3'b010, ORG_CPU, TGT_HUB);
      wr(REG_SEG_WE, 32'h1100);
      g(36'h0000ffff0, 3'b010, ORG_CPU, TGT_SDRAM);
      g(36'h0000ffff0, 3'b000, ORG_CPU, TGT_HUB);
      wr(REG_SEG_RD_EN, 32'h1001);
      g(36'h0000f8000, 3'b000, ORG_CPU, TGT_SDRAM);
      rd(REG_SEG_RD_EN, 32'h1001);
      g(36'h000200000, 3'b000, ORG_CPU, TGT_SDRAM);
      g(36'h000f00000, 3'b000, ORG_CPU, TGT_SDRAM);
      wr(REG_LEGACY, 32'h10);
      g(36'h000f00000, 3'b010, ORG_CPU, TGT_HUB);
      g(36'h000fffff0, 3'b000, ORG_CPU, TGT_HUB);
      g(36'h000effff0, 3'b000, ORG_CPU, TGT_SDRAM);
      g(36'h001000000, 3'b000, ORG_CPU, TGT_HUB);
      wr(REG_TOP_MEM, 32'hfff);
      rd(REG_TOP_MEM, 32'h800);
      g(36'h07ffffff0, 3'b000, ORG_CPU, TGT_SDRAM);
      g(36'h080000000, 3'b000, ORG_CPU, TGT_HUB);
      g(36'h0fec00000, 3'b000, ORG_CPU, TGT_HUB);
      g(36'h0ffe00000, 3'b000, ORG_CPU, TGT_HUB);
      g(36'h100000000, 3'b000, ORG_CPU, TGT_LOCAL, 2'b10);
      g(36'h1000000f0, 3'b010, ORG_CPU, TGT_LOCAL, 2'b01);
      // Eighteen hub-bound cycles were issued above
      rd(REG_STATUS, 32'h12);
      final_report();
   end

   // Roughly 115 cycles of traffic; ample margin before giving up
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
endmodule
